// ### rtl/sram_ctl_pkg.sv
package sram_ctl_pkg;
	localparam int CLK_PERIOD_NS = 20;
	localparam int ADDR_W        = 16;
	localparam int DATA_W        = 16;
	localparam int LANES         = 2;
	// fastest grade figures in ns
	localparam int T_READ_ACCESS_NS     = 10;
	localparam int T_WRITE_PULSE_NS     = 7;
	localparam int T_WE_LOW_RELEASE_NS  = 5;
	localparam int T_DATA_SETUP_NS      = 5;
	localparam int T_CS_HIGH_RELEASE_NS = 5;
	localparam int T_WRITE_CYCLE_NS     = 10;
	localparam int data_setup_to_write_end = T_DATA_SETUP_NS;
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int READ_CYC    = ns_to_cyc(T_READ_ACCESS_NS) + 1;
	localparam int WRITE_CYC   = ns_to_cyc(T_WE_LOW_RELEASE_NS
		+ data_setup_to_write_end);
	localparam int TURN_CYC    = ns_to_cyc(T_CS_HIGH_RELEASE_NS);
	localparam int SETUP_CYC   = ns_to_cyc(T_WRITE_CYCLE_NS - T_WRITE_PULSE_NS);
	localparam logic [3:0] CNT_READ  = 4'(READ_CYC);
	localparam logic [3:0] CNT_WRITE = 4'(WRITE_CYC);
	localparam logic [3:0] CNT_TURN  = 4'(TURN_CYC);
	localparam logic [3:0] CNT_SETUP = 4'(SETUP_CYC);

	typedef struct packed {
		logic                 write;
		logic [ADDR_W-1:0]    addr;
		logic [DATA_W-1:0]    wdata;
		logic [LANES-1:0]     lane_en;
	} req_t;

	typedef struct packed {
		logic              cs_n;
		logic              we_n;
		logic              oe_n;
		logic              lower_lane_sel_n;
		logic              upper_lane_sel_n;
		logic [ADDR_W-1:0] addr;
	} pins_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_READ  = 3'b001,
		ST_WSET  = 3'b010,
		ST_WRITE = 3'b011,
		ST_TURN  = 3'b100
	} state_t;
endpackage

// ### rtl/sram_cycle_timer.sv
`timescale 1ns/100ps
module sram_cycle_timer (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       load,
	input  wire logic [3:0] value,
	output logic            done
);
	logic [3:0] cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 4'h0;
		end else if (load) begin
			cnt <= value;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end
	// done is high in the last cycle of a loaded interval; it must not
	// look at load, which the sequencer itself decodes from done
	assign done = (cnt == 4'h1);
endmodule

// ### rtl/sram_host_ctl.sv
`timescale 1ns/100ps
module sram_host_ctl (
	input  wire logic                               clk,
	input  wire logic                               nrst,
	input  wire logic                               req_valid,
	input  wire sram_ctl_pkg::req_t                 req,
	output logic                                    req_ready,
	output logic                                    rsp_valid,
	output logic [sram_ctl_pkg::DATA_W-1:0]         rsp_data,
	output sram_ctl_pkg::pins_t                     pins,
	input  wire logic [sram_ctl_pkg::DATA_W-1:0]    dq_in,
	output logic [sram_ctl_pkg::DATA_W-1:0]         dq_out,
	output logic [sram_ctl_pkg::DATA_W-1:0]         dq_oe
);
	import sram_ctl_pkg::*;

	// ==========================================================
	// reset and pin input synchronisation
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	logic [DATA_W-1:0] dq_sync;
	sram_sync2 #(.W(DATA_W)) u_dq_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (dq_in),
		.q     (dq_sync)
	);

	// ==========================================================
	// sequencer
	state_t     state;
	state_t     next_state;
	logic       tmr_load;
	logic [3:0] tmr_value;
	logic       tmr_done;
	req_t       cur;

	sram_cycle_timer u_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.load  (tmr_load),
		.value (tmr_value),
		.done  (tmr_done)
	);

	wire accept = (state == ST_IDLE) && req_valid && req_ready;

	always_comb begin
		next_state = state;
		tmr_load   = 1'b0;
		tmr_value  = 4'h0;
		case (state)
		ST_IDLE: begin
			if (accept) begin
				// address and lanes set up a full interval before we falls
				tmr_load   = 1'b1;
				next_state = req.write ? ST_WSET : ST_READ;
				tmr_value  = req.write ? CNT_SETUP : CNT_READ;
			end
		end
		ST_READ: begin
			if (tmr_done) begin
				next_state = ST_TURN;
				tmr_load   = 1'b1;
				tmr_value  = CNT_TURN;
			end
		end
		ST_WSET: begin
			if (tmr_done) begin
				next_state = ST_WRITE;
				tmr_load   = 1'b1;
				tmr_value  = CNT_WRITE;
			end
		end
		ST_WRITE: begin
			if (tmr_done) begin
				next_state = ST_TURN;
				tmr_load   = 1'b1;
				tmr_value  = CNT_TURN;
			end
		end
		ST_TURN: begin
			// bus recovery before the next access may start
			if (tmr_done) begin
				next_state = ST_IDLE;
			end
		end
		default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
		end else if (accept) begin
			cur <= req;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_ready <= 1'b0;
		end else begin
			req_ready <= (next_state == ST_IDLE) && !accept;
		end
	end

	// ==========================================================
	// memory pins
	// we goes low after cs and lanes so the memory never drives
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pins <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
				lower_lane_sel_n: 1'b1, upper_lane_sel_n: 1'b1,
				addr: '0};
		end else begin
			case (next_state)
			ST_READ, ST_WSET, ST_WRITE: begin
				// address taken with select, held to write end
				pins.addr             <= accept ? req.addr : cur.addr;
				pins.cs_n             <= 1'b0;
				pins.lower_lane_sel_n <= !(accept ? req.lane_en[0]
					: cur.lane_en[0]);
				pins.upper_lane_sel_n <= !(accept ? req.lane_en[1]
					: cur.lane_en[1]);
				pins.we_n  <= (next_state != ST_WRITE);
				pins.oe_n  <= (next_state != ST_READ);
			end
			default: begin
				pins.cs_n             <= 1'b1;
				pins.we_n             <= 1'b1;
				pins.oe_n             <= 1'b1;
				pins.lower_lane_sel_n <= 1'b1;
				pins.upper_lane_sel_n <= 1'b1;
			end
			endcase
		end
	end

	// ==========================================================
	// data bus: driven only inside the we-low window, oe held high
	genvar b;
	generate
		for (b = 0; b < DATA_W; b++) begin : g_dq
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					dq_oe[b] <= 1'b0;
				end else begin
					dq_oe[b] <= (next_state == ST_WRITE)
						&& cur.lane_en[b/8];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dq_out <= '0;
		end else if (accept) begin
			dq_out <= req.wdata;
		end
	end

	// ==========================================================
	// read capture: sampled at the end of the access through the sync
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_data  <= '0;
		end else begin
			rsp_valid <= (state == ST_TURN) && tmr_done && !cur.write;
			if ((state == ST_TURN) && tmr_done && !cur.write) begin
				rsp_data <= dq_sync;
			end
		end
	end

	// ==========================================================
	// checks
	default clocking chk_clk @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// strobe low time in cycles; a strobe stuck low wraps at 16
	logic [3:0]        we_low_cnt;
	logic [3:0]        oe_low_cnt;
	logic [DATA_W-1:0] lane_mask;
	assign lane_mask = {{8{!pins.upper_lane_sel_n}},
		{8{!pins.lower_lane_sel_n}}};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			we_low_cnt <= 4'h0;
		end else if (pins.we_n) begin
			we_low_cnt <= 4'h0;
		end else begin
			we_low_cnt <= we_low_cnt + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oe_low_cnt <= 4'h0;
		end else if (pins.oe_n) begin
			oe_low_cnt <= 4'h0;
		end else begin
			oe_low_cnt <= oe_low_cnt + 4'h1;
		end
	end

	// ==========================================================
	// write strobe: oe stays high so the plain pulse limit applies
	AST_WRITE_OVERLAP: assert property (
		!pins.we_n |-> !pins.cs_n
		&& !(pins.lower_lane_sel_n && pins.upper_lane_sel_n))
		else $error("write enable low without select");
	AST_WE_PULSE: assert property (
		$rose(pins.we_n) |-> we_low_cnt >= CNT_WRITE)
		else $error("write pulse too short");
	AST_OE_IN_WRITE: assert property (
		!pins.we_n |-> pins.oe_n)
		else $error("output enable low in write");
	AST_SEL_BEFORE_WE: assert property (
		$fell(pins.we_n) |-> $past(!pins.cs_n))
		else $error("select did not precede write enable");
	AST_ADDR_SETUP: assert property (
		$rose(pins.we_n) |-> $past(pins.addr) == $past(pins.addr, 2))
		else $error("address setup short");
	AST_CS_SETUP: assert property (
		$rose(pins.we_n) |-> $past(!pins.cs_n) && $past(!pins.cs_n, 2))
		else $error("select setup short");
	AST_LANE_SETUP: assert property (
		$rose(pins.we_n) |-> $past(lane_mask) == $past(lane_mask, 2))
		else $error("lane enable setup short");
	AST_DATA_SETUP: assert property (
		$rose(pins.we_n) |-> $past(dq_oe) == $past(lane_mask))
		else $error("write data missing at write end");
	AST_DATA_LANES: assert property (
		!pins.we_n |-> dq_oe == lane_mask)
		else $error("write data lanes differ from lane enables");

	// ==========================================================
	// select, address and bus ownership
	AST_ADDR_STABLE: assert property (
		!pins.cs_n && $past(!pins.cs_n) |-> $stable(pins.addr))
		else $error("address moved during access");
	AST_NO_CONTENTION: assert property (
		(dq_oe != '0) |-> pins.oe_n && !pins.we_n)
		else $error("data driven while memory may drive");
	// two cycles with select high let the memory release the bus
	AST_TURN_GAP: assert property (
		$rose(pins.cs_n) |=> pins.cs_n)
		else $error("select reopened without turnaround");
	// a new request cannot move the address in mid-access
	AST_READY_IDLE: assert property (
		req_ready |-> state == ST_IDLE)
		else $error("ready outside idle");

	// ==========================================================
	// read strobe and response
	AST_READ_WE_HIGH: assert property (
		!pins.oe_n |-> pins.we_n && dq_oe == '0)
		else $error("write enable low in read");
	AST_READ_OPEN: assert property (
		$fell(pins.oe_n) |-> $fell(pins.cs_n))
		else $error("read opened without select");
	// read strobe covers the access time plus a cycle for the data sync
	AST_READ_LEN: assert property (
		$rose(pins.oe_n) |-> oe_low_cnt >= CNT_READ)
		else $error("read strobe too short");
	AST_READ_DONE: assert property (
		$fell(pins.oe_n) |-> ##[1:8] rsp_valid)
		else $error("read response late");
	AST_RSP_PULSE: assert property (
		rsp_valid |=> !rsp_valid)
		else $error("response longer than one cycle");

	// scenarios the bench is expected to reach
	COV_READ: cover property (@(posedge clk) $fell(pins.oe_n));
	COV_WRITE: cover property (@(posedge clk) $fell(pins.we_n));
	COV_LOW_LANE: cover property (@(posedge clk)
		!pins.we_n && pins.upper_lane_sel_n);
	COV_HIGH_READ: cover property (@(posedge clk)
		!pins.oe_n && pins.lower_lane_sel_n);
	COV_B2B: cover property (@(posedge clk) rsp_valid ##[1:4] accept);
endmodule

// ### rtl/sram_sync2.sv
`timescale 1ns/100ps
module sram_sync2 #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// ### test/async_sram_16bit_byte_lanes_tb.sv
`timescale 1ns/100ps
module async_sram_16bit_byte_lanes_tb;
	import sram_ctl_pkg::*;
	logic              clk = 1'b0;
	logic              nrst = 1'b0;
	logic              req_valid = 1'b0;
	req_t              req = '0;
	logic              req_ready;
	logic              rsp_valid;
	logic [DATA_W-1:0] rsp_data;
	logic [DATA_W-1:0] dq_in;
	logic [DATA_W-1:0] dq_out;
	logic [DATA_W-1:0] dq_oe;
	logic [DATA_W-1:0] q;
	logic [DATA_W-1:0] q_en;
	logic [DATA_W-1:0] noise = 16'hA5C3;
	logic [DATA_W-1:0] e;
	logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
	logic [DATA_W-1:0] exp_q [$];
	logic [DATA_W-1:0] msk_q [$];
	logic [ADDR_W-1:0] addrs [8];
	logic [31:0]       seed = 32'hABE91F2D;
	pins_t             pins;
	int                errors = 0;
	int                samples_checked = 0;

	always #10 clk = ~clk;
	// undriven lines wander every cycle rather than hold a stale value
	assign dq_in = (dq_oe & dq_out) | (~dq_oe & q_en & q)
		| (~dq_oe & ~q_en & noise);

	sram_host_ctl i_dut (
		.clk      (clk),
		.nrst     (nrst),
		.req_valid(req_valid),
		.req      (req),
		.req_ready(req_ready),
		.rsp_valid(rsp_valid),
		.rsp_data (rsp_data),
		.pins     (pins),
		.dq_in    (dq_in),
		.dq_out   (dq_out),
		.dq_oe    (dq_oe)
	);

	sram_model i_mem (
		.pins(pins),
		.bus (dq_in),
		.q   (q),
		.q_en(q_en)
	);

	// ========================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	task automatic chk(input string what, input logic [15:0] ex,
		input logic [15:0] got);
		samples_checked++;
		if (got !== ex) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, ex, got);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic access(input logic wr, input logic [15:0] a,
		input logic [15:0] d, input logic [1:0] ln);
		logic [15:0] m;
		int          n;
		m = {{8{ln[1]}}, {8{ln[0]}}};
		n = 0;
		@(posedge clk);
		#1;
		req = '{write: wr, addr: a, wdata: d, lane_en: ln};
		req_valid = 1'b1;
		// ready is registered: look at it once settled, then the
		// next rising edge is the one that takes the request
		while (req_ready !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 50) begin
				errors++;
				$display("[FAIL] req_ready expected 1 seen 0");
				close_out();
			end
		end
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		if (wr)
			shadow[a] = (shadow[a] & ~m) | (d & m);
		else begin
			exp_q.push_back(shadow[a] & m);
			msk_q.push_back(m);
		end
	endtask

	// ========================================
	// output watcher
	always @(negedge clk) begin
		noise <= ~noise;
		if ((dq_oe & q_en) !== '0)
			chk("bus clash", 16'h0, dq_oe & q_en);
		if (pins.we_n === 1'b0)
			chk("select in write", 16'h0, 16'(pins.cs_n));
		if (pins.oe_n === 1'b0)
			chk("write enable in read", 16'h1, 16'(pins.we_n));
		if (rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("read count", 16'h0, 16'h1);
			end else begin
				e = exp_q.pop_front();
				chk("read data", e, rsp_data & msk_q.pop_front());
			end
		end
	end

	// ========================================
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		chk("select in reset", 16'h1, 16'(pins.cs_n));
		#1 nrst = 1'b1;
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			addrs[i] = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : seed[31:16];
			access(1'b1, addrs[i], seed[15:0], 2'b11);
		end
		$display("test word writes done");
		for (int i = 0; i < 8; i++)
			access(1'b0, addrs[i], 16'h0, 2'b11);
		$display("test word reads done");
		for (int i = 0; i < 80; i++) begin
			seed = xs(seed);
			access(seed[0], addrs[seed[3:1]], seed[31:16],
				seed[5:4] == 2'b00 ? 2'b11 : seed[5:4]);
		end
		for (int n = 0; exp_q.size() != 0; n++) begin
			@(posedge clk);
			if (n > 50) begin
				errors++;
				$display("[FAIL] responses expected 0 seen %0d", exp_q.size());
				break;
			end
		end
		$display("test mixed lanes done");
		close_out();
	end
endmodule

// ### test/sram_model.sv
`timescale 1ns/100ps
module sram_model (
	input  wire sram_ctl_pkg::pins_t             pins,
	input  wire logic [sram_ctl_pkg::DATA_W-1:0] bus,
	output logic      [sram_ctl_pkg::DATA_W-1:0] q,
	output logic      [sram_ctl_pkg::DATA_W-1:0] q_en
);
	import sram_ctl_pkg::*;
	// ========================================
	// storage and lanes
	logic [DATA_W-1:0] mem [0:65535];
	logic [LANES-1:0]  lane;
	logic [DATA_W-1:0] bus_d;
	logic              rd;

	initial q_en = '0;
	assign lane = ~{pins.upper_lane_sel_n, pins.lower_lane_sel_n};
	assign rd = !pins.cs_n && !pins.oe_n && pins.we_n;
	assign #4 q = mem[pins.addr];
	// delayed copy so a bus released with the strobes is not stored
	assign #1 bus_d = bus;

	// ========================================
	// read drive and release, slowest legal timing
	always @(pins or rd) begin
		q_en <= #3 '0;
		if (rd) begin
			q_en <= #8 {{8{lane[1]}}, {8{lane[0]}}};
		end
	end

	// ========================================
	// write during overlap of select, lane and write enable
	always @(pins or bus_d) begin
		if (!pins.cs_n && !pins.we_n) begin
			if (lane[0])
				mem[pins.addr][7:0] = bus_d[7:0];
			if (lane[1])
				mem[pins.addr][15:8] = bus_d[15:8];
		end
	end
endmodule
